// ---- src/i2c_ack_stop_clock_sync.sv ----
// Two-wire port: clock holding, acknowledge and stop sequences, APB registers
//
// Operation
// - Cleared release waits for SCL low, holds it
// - Clearing release never drives SCL by itself
// - Hold until release set; wire rises later
// - Ack start pulls SCL low, drives ack data
// - Ack data zero acks, one not-acks
// - Ack: period, release SCL, high, period, low
// - Ack end clears enable, stops baud, idles
// - Buffer write during ack sets collision flag
// - Master holds SCL after ninth falling edge
// - Stop: SDA low, period, SCL high, period, SDA up
// - SDA high with SCL high sets stop seen
// - Period after stop: clear enable, interrupt
// - Buffer write during stop sets collision flag
// - Ack status one means no ack received
// - Master receive enable selects receive mode
// - Slave stretch bit enables stretching after ack
// - Busy port blocks enables but general call, and buffer writes
`timescale 1ns/1ns
`default_nettype none
module i2c_ack_stop_clock_sync
  import i2c_ack_stop_pkg::*;
(
  input  wire  logic     clk_sys,
  input  wire  logic     rst,
  input  wire  apb_req_s apbReq,
  output var   apb_rsp_s apbRsp,
  input  wire  pin_in_s  pinIn,
  output var   pin_out_s pinOut,
  output logic           receiveMode,
  output logic           irq
);
  // ==========================================================
  // State and decode
  port_state_s st;          // Registered state
  port_state_s next_st;     // Next state
  logic        setup;       // APB setup cycle
  logic        access;      // APB access, always ready
  logic        wr;          // Write taking effect
  logic        busy;        // A sequence is running
  logic        bufWr;       // Buffer write taking effect
  logic        sclRise;     // Synced SCL edges
  logic        sclFall;
  logic        sdaRise;     // Synced SDA edges
  logic        sdaFall;
  logic        brgDone;     // Baud period elapsed
  logic [7:0]  wByte;       // Low write byte

  assign setup   = apbReq.psel && !apbReq.penable;
  assign access  = apbReq.psel && apbReq.penable;
  assign wr      = access && apbReq.pwrite;
  assign busy    = st.state != S_IDLE;
  assign bufWr   = wr && apbReq.paddr == OFF_BUFFER;
  assign sclRise = st.sclSync && !st.sclPrev;
  assign sclFall = !st.sclSync && st.sclPrev;
  assign sdaRise = st.sdaSync && !st.sdaPrev;
  assign sdaFall = !st.sdaSync && st.sdaPrev;
  assign brgDone = st.brg == 8'h00;
  assign wByte   = apbReq.pwdata[7:0];

  // Registered outputs except pready, which follows access, and irq and receiveMode, gated from registers; pins are open drain so data is always low
  assign apbRsp.prdata  = st.rdata;
  assign apbRsp.pready  = access;
  assign apbRsp.pslverr = st.slvErr;
  assign pinOut.sclOut  = 1'b0;
  assign pinOut.sdaOut  = 1'b0;
  assign pinOut.sclOe   = st.sclOe;
  assign pinOut.sdaOe   = st.sdaOe;
  assign receiveMode    = st.master && st.ctrl2[CT2_RECEIVE];
  assign irq            = |(st.intStat & st.intEn);

  // ==========================================================
  // Next state
  always_comb
  begin
    next_st = st;
    // Two-flop synchronisers plus an edge flop; the second and third flops feed logic
    next_st.sclMeta = pinIn.scl;
    next_st.sclSync = st.sclMeta;
    next_st.sclPrev = st.sclSync;
    next_st.sdaMeta = pinIn.sda;
    next_st.sdaSync = st.sdaMeta;
    next_st.sdaPrev = st.sdaSync;
    next_st.slvErr  = 1'b0;

    // Read data captured in setup so prdata is a flop
    if (setup && !apbReq.pwrite)
    begin
      next_st.rdata = 32'h0000_0000;
      case (apbReq.paddr)
        OFF_CTRL_ONE: next_st.rdata[1:0] = {st.master, st.clkRel};
        OFF_CTRL_TWO: next_st.rdata[7:0] = st.ctrl2;
        OFF_STATUS:   next_st.rdata[2:0] = {busy, st.startDet, st.stopDet};
        OFF_BUFFER:   next_st.rdata[7:0] = st.buffer;
        OFF_RELOAD:   next_st.rdata[7:0] = st.reload;
        OFF_INT_STAT: next_st.rdata[2:0] = st.intStat;
        OFF_INT_EN:   next_st.rdata[2:0] = st.intEn;
        OFF_INT_CLR:  next_st.rdata      = 32'h0000_0000; // Write only
        default:      next_st.slvErr     = 1'b1;          // Unmapped
      endcase
    end
    else if (setup)
    begin
      // Unmapped write answers with an error
      case (apbReq.paddr)
        OFF_CTRL_ONE, OFF_CTRL_TWO, OFF_STATUS, OFF_BUFFER,
        OFF_RELOAD, OFF_INT_STAT, OFF_INT_CLR, OFF_INT_EN:
          next_st.slvErr = 1'b0;
        default:
          next_st.slvErr = 1'b1;
      endcase
    end

    // Register writes; clears come first so hardware sets win
    if (wr)
    begin
      case (apbReq.paddr)
        OFF_CTRL_ONE:
        begin
          next_st.clkRel = wByte[CT1_CLOCK_RELEASE];
          next_st.master = wByte[CT1_MASTER];
        end
        OFF_CTRL_TWO:
        begin
          next_st.ctrl2[CT2_GEN_CALL] = wByte[CT2_GEN_CALL];
          next_st.ctrl2[CT2_ACK_DATA] = wByte[CT2_ACK_DATA];
          // Enables but general call only move while idle, nothing is queued
          if (!busy)
          begin
            next_st.ctrl2[CT2_ACK_SEQ] = wByte[CT2_ACK_SEQ] && st.master;
            next_st.ctrl2[CT2_RECEIVE] = wByte[CT2_RECEIVE] && st.master;
            next_st.ctrl2[CT2_STOP]    = wByte[CT2_STOP] && st.master;
            next_st.ctrl2[CT2_RESTART] = wByte[CT2_RESTART] && st.master;
            next_st.ctrl2[CT2_START_STRETCH] = wByte[CT2_START_STRETCH];
          end
        end
        OFF_BUFFER:
        begin
          if (busy)
            next_st.intStat[INT_COLLIDE] = 1'b1;
          else
            next_st.buffer = wByte;
        end
        OFF_RELOAD:  next_st.reload = wByte;
        OFF_INT_CLR: next_st.intStat = st.intStat & ~wByte[2:0];
        OFF_INT_EN:  next_st.intEn = wByte[2:0];
        default:     next_st.reload = st.reload;
      endcase
    end

    // Bus conditions; either one clears the other
    if (sdaFall && st.sclSync)
    begin
      next_st.startDet = 1'b1;
      next_st.stopDet  = 1'b0;
      next_st.bits     = 4'h0;
    end
    else if (sdaRise && st.sclSync)
    begin
      next_st.stopDet  = 1'b1;
      next_st.startDet = 1'b0;
    end
    else if (sclRise)
    begin
      // Bit counter and shift register on rising SCL
      next_st.bits  = st.bits + 4'h1;
      next_st.shift = {st.shift[6:0], st.sdaSync};
      if (st.bits == 4'h7 && !st.master && st.ctrl2[CT2_GEN_CALL]
          && {st.shift[6:0], st.sdaSync} == GEN_CALL_ADDR)
        next_st.intStat[INT_GCALL] = 1'b1;
    end
    else if (sclFall && st.bits == BITS_PER_ACK)
    begin
      next_st.bits = 4'h0;
      if (st.master)
        next_st.mHold = 1'b1;
      else if (st.ctrl2[CT2_START_STRETCH])
        next_st.clkRel = 1'b0;
    end

    // Ack status taken on the ninth rising edge as master
    if (!(sdaFall && st.sclSync) && !(sdaRise && st.sclSync) && sclRise
        && st.bits == BITS_PER_ACK - 4'h1 && st.master)
      next_st.ctrl2[CT2_ACKST] = st.sdaSync;

    // Software hold joins only once SCL is already low
    if (next_st.clkRel)
      next_st.cpHold = 1'b0;
    else
      next_st.cpHold = st.cpHold || !st.sclSync;

    // Baud generator counts only while a sequence runs
    if (busy && !brgDone)
      next_st.brg = st.brg - 8'h01;

    // Acknowledge and stop sequencer
    case (st.state)
      S_IDLE:
      begin
        next_st.brg = st.reload;
        if (st.ctrl2[CT2_ACK_SEQ])
        begin
          next_st.mHold  = 1'b1;
          next_st.sdaDrv = !st.ctrl2[CT2_ACK_DATA];
          next_st.state  = S_ACK_LOW;
        end
        else if (st.ctrl2[CT2_STOP])
        begin
          next_st.sdaDrv = 1'b1;
          next_st.state  = S_STP_SDA;
        end
      end
      S_ACK_LOW:
      begin
        if (brgDone)
        begin
          next_st.mHold = 1'b0;
          next_st.state = S_ACK_REL;
        end
      end
      S_ACK_REL:
      begin
        // Wait out any other master still holding SCL
        next_st.brg = st.reload;
        if (st.sclSync)
          next_st.state = S_ACK_HI;
      end
      S_ACK_HI:
      begin
        if (brgDone)
        begin
          next_st.mHold            = 1'b1;
          next_st.sdaDrv           = 1'b0;
          next_st.ctrl2[CT2_ACK_SEQ] = 1'b0;
          next_st.state            = S_IDLE;
        end
      end
      S_STP_SDA:
      begin
        next_st.brg = st.reload;
        if (!st.sdaSync)
          next_st.state = S_STP_CNT;
      end
      S_STP_CNT:
      begin
        if (brgDone)
        begin
          next_st.mHold = 1'b0;
          next_st.brg   = st.reload;
          next_st.state = S_STP_SCL;
        end
      end
      S_STP_SCL:
      begin
        if (brgDone)
        begin
          next_st.sdaDrv = 1'b0;
          next_st.state  = S_STP_WP;
        end
      end
      S_STP_WP:
      begin
        next_st.brg = st.reload;
        if (st.sdaSync && st.sclSync)
        begin
          next_st.stopDet = 1'b1;
          next_st.state   = S_STP_END;
        end
      end
      S_STP_END:
      begin
        if (brgDone)
        begin
          next_st.ctrl2[CT2_STOP]   = 1'b0;
          next_st.intStat[INT_PORT] = 1'b1;
          next_st.state            = S_IDLE;
        end
      end
      default:
        next_st.state = S_IDLE;
    endcase

    // Pin enables registered from the next hold state
    next_st.sclOe = next_st.cpHold || next_st.mHold;
    next_st.sdaOe = next_st.sdaDrv;
  end

  // ==========================================================
  // State register
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      st        <= '0;
      st.state  <= S_IDLE;
      st.reload <= RST_RELOAD;
      st.clkRel <= RST_CLK_REL;
      st.ctrl2  <= RST_CTRL_TWO;
      st.sclMeta <= 1'b1;
      st.sclSync <= 1'b1;
      st.sclPrev <= 1'b1;
      st.sdaMeta <= 1'b1;
      st.sdaSync <= 1'b1;
      st.sdaPrev <= 1'b1;
    end
    else
      st <= next_st;
  end

  // ==========================================================
  // Assertions
  property p_holdAfterLow;
    @(posedge clk_sys) disable iff (rst)
    $rose(st.cpHold) |-> !$past(st.sclSync);
  endproperty
  a_holdAfterLow: assert property (p_holdAfterLow)
    else $error("software hold began while SCL high");

  property p_holdDrives;
    @(posedge clk_sys) disable iff (rst)
    st.cpHold |-> st.sclOe && !st.clkRel;
  endproperty
  a_holdDrives: assert property (p_holdDrives)
    else $error("held SCL not driven or release set");

  property p_ackDrive;
    @(posedge clk_sys) disable iff (rst)
    st.state == S_ACK_LOW |-> st.sclOe && st.sdaOe == !st.ctrl2[CT2_ACK_DATA];
  endproperty
  a_ackDrive: assert property (p_ackDrive)
    else $error("ack phase pins wrong");

  property p_ackEnd;
    @(posedge clk_sys) disable iff (rst)
    $fell(st.ctrl2[CT2_ACK_SEQ]) |-> st.state == S_IDLE && $past(st.state) == S_ACK_HI;
  endproperty
  a_ackEnd: assert property (p_ackEnd)
    else $error("ack enable cleared out of sequence");

  property p_write_collision_flag;
    @(posedge clk_sys) disable iff (rst)
    busy && bufWr |=> st.intStat[INT_COLLIDE] && st.buffer == $past(st.buffer);
  endproperty
  a_write_collision_flag: assert property (p_write_collision_flag)
    else $error("busy buffer write not refused");

  property p_stopSda;
    @(posedge clk_sys) disable iff (rst)
    st.state == S_STP_SDA |-> st.sdaOe ##0 (st.state == S_STP_SDA)[*1];
  endproperty
  a_stopSda: assert property (p_stopSda)
    else $error("stop did not drive SDA low");

  property p_stopSeen;
    @(posedge clk_sys) disable iff (rst)
    st.state == S_STP_WP && st.sclSync && st.sdaSync |=> st.stopDet ##1 st.stopDet;
  endproperty
  a_stopSeen: assert property (p_stopSeen)
    else $error("stop not flagged");

  property p_stopIrq;
    @(posedge clk_sys) disable iff (rst)
    $fell(st.ctrl2[CT2_STOP]) |-> st.intStat[INT_PORT] && $past(brgDone);
  endproperty
  a_stopIrq: assert property (p_stopIrq)
    else $error("stop end without interrupt flag");

  property p_noSetBusy;
    @(posedge clk_sys) disable iff (rst)
    busy |=> !$rose(st.ctrl2[CT2_RECEIVE]) && !$rose(st.ctrl2[CT2_START_STRETCH]);
  endproperty
  a_noSetBusy: assert property (p_noSetBusy)
    else $error("enable set while busy");

  property p_brgCount;
    @(posedge clk_sys) disable iff (rst)
    st.state == S_ACK_LOW && !brgDone |=> st.brg == $past(st.brg) - 8'h01;
  endproperty
  a_brgCount: assert property (p_brgCount)
    else $error("baud generator not counting");
endmodule
`default_nettype wire

// ---- src/i2c_ack_stop_pkg.sv ----
// Package: register map, field layout, reset values, states and carriers
package i2c_ack_stop_pkg;
  // ==========================================================
  // Register byte offsets on APB
  localparam logic [7:0] OFF_CTRL_ONE = 8'h00; // Clock release, mode
  localparam logic [7:0] OFF_CTRL_TWO = 8'h04; // i2c_control_two
  localparam logic [7:0] OFF_STATUS   = 8'h08; // serial_status_register
  localparam logic [7:0] OFF_BUFFER   = 8'h0C; // serial_data_buffer
  localparam logic [7:0] OFF_RELOAD   = 8'h10; // Baud reload count
  localparam logic [7:0] OFF_INT_STAT = 8'h14; // Sticky events, read only
  localparam logic [7:0] OFF_INT_CLR  = 8'h18; // Write one to clear
  localparam logic [7:0] OFF_INT_EN   = 8'h1C; // Event enables
  // ==========================================================
  // Field positions
  localparam int CT1_CLOCK_RELEASE = 0;
  localparam int CT1_MASTER        = 1;
  localparam int CT2_START_STRETCH = 0; // start_or_stretch_enable
  localparam int CT2_RESTART       = 1; // restart_seq_enable
  localparam int CT2_STOP          = 2; // stop_seq_enable
  localparam int CT2_RECEIVE       = 3; // receive_enable
  localparam int CT2_ACK_SEQ       = 4; // ack_seq_enable
  localparam int CT2_ACK_DATA      = 5; // ack_data_value
  localparam int CT2_ACKST         = 6; // ack_received_status
  localparam int CT2_GEN_CALL      = 7; // general_call_enable
  localparam int ST_STOP   = 0;
  localparam int ST_START  = 1;
  localparam int ST_BUSY   = 2;
  localparam int INT_PORT  = 0; // port_interrupt_flag
  localparam int INT_COLLIDE = 1; // write_collision_flag
  localparam int INT_GCALL = 2; // General call seen
  // ==========================================================
  // Reset values and counts
  localparam logic [7:0] RST_CTRL_TWO  = 8'h00;
  localparam logic [7:0] RST_RELOAD    = 8'h04;
  localparam logic       RST_CLK_REL   = 1'b1;
  localparam logic [7:0] GEN_CALL_ADDR = 8'h00;
  localparam logic [3:0] BITS_PER_ACK  = 4'h9; // Eight data plus ack
  // ==========================================================
  // Port sequencer states
  typedef enum logic [8:0] {
    S_IDLE    = 9'h001,
    S_ACK_LOW = 9'h002,
    S_ACK_REL = 9'h004,
    S_ACK_HI  = 9'h008,
    S_STP_SDA = 9'h010,
    S_STP_CNT = 9'h020,
    S_STP_SCL = 9'h040,
    S_STP_WP  = 9'h080,
    S_STP_END = 9'h100
  } port_state_e;
  // ==========================================================
  // Carriers
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } apb_req_s;
  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } apb_rsp_s;
  typedef struct packed {
    logic scl;
    logic sda;
  } pin_in_s;
  typedef struct packed {
    logic sclOut;
    logic sclOe;
    logic sdaOut;
    logic sdaOe;
  } pin_out_s;
  // Whole state of the port
  typedef struct packed {
    port_state_e state;
    logic [7:0]  brg;
    logic [7:0]  reload;
    logic        clkRel;
    logic        master;
    logic [7:0]  ctrl2;
    logic        stopDet;
    logic        startDet;
    logic [7:0]  buffer;
    logic [7:0]  shift;
    logic [3:0]  bits;
    logic [2:0]  intStat;
    logic [2:0]  intEn;
    logic        cpHold;
    logic        mHold;
    logic        sdaDrv;
    logic        sclOe;
    logic        sdaOe;
    logic [31:0] rdata;
    logic        slvErr;
    logic        sclMeta;
    logic        sclSync;
    logic        sclPrev;
    logic        sdaMeta;
    logic        sdaSync;
    logic        sdaPrev;
  } port_state_s;
endpackage

// ---- test/i2c_bus_partner.sv ----
// Behavioural model of another master on the two-wire bus, with pull-ups
`timescale 1ns/1ns
`default_nettype none
module i2c_bus_partner
  import i2c_ack_stop_pkg::*;
(
  input  wire pin_out_s pinOut,
  output wire pin_in_s  pinIn
);
  // ====================
  // Line drivers
  logic extScl = 1'b1; // Partner pulls SCL low when 0
  logic extSda = 1'b1; // Partner pulls SDA low when 0

  // Open drain: a line is high only when every party lets go of it
  assign pinIn = '{scl: extScl & ~pinOut.sclOe, sda: extSda & ~pinOut.sdaOe};

  // ====================
  // Clocking, 64 ns period while a frame runs
  // One bit; a stretching device keeps the wire low and we wait,
  // a stuck wire is ended by the bench watchdog
  task automatic pulse(input logic v);
    extScl = 1'b0;
    #16 extSda = v;
    #16 extScl = 1'b1;
    while (pinIn.scl !== 1'b1)
      #8;
    #32;
  endtask

  // Start, eight bits, ack bit, then SCL released low-to-high
  task automatic sendByte(input logic [7:0] b, input logic ack);
    // Step off the clock edge so the wires never race the samplers
    #2;
    extSda = 1'b0;
    #32;
    for (int i = 7; i >= 0; i--)
      pulse(b[i]);
    pulse(ack);
    extScl = 1'b0;
    #32 extSda = 1'b1;
    extScl = 1'b1;
  endtask
endmodule
`default_nettype wire

// ---- test/tb_i2c_ack_stop_clock_sync.sv ----
// Self-checking bench for the port's clock hold, ack and stop sequences
`timescale 1ns/1ns
`default_nettype none
module tb_i2c_ack_stop_clock_sync
  import i2c_ack_stop_pkg::*;
;
  // ====================
  // Signals
  logic        clk_sys    = 1'b0;
  logic        rst        = 1'b1;
  apb_req_s    apbReq     = '0;
  apb_rsp_s    apbRsp;
  pin_in_s     pinIn;
  pin_out_s    pinOut;
  logic        receiveMode;
  logic        irq;
  int          fail_count = 0;
  int          compares   = 0;
  int          cycles     = 0;

  always #4 clk_sys = ~clk_sys;

  i2c_ack_stop_clock_sync DUT (.clk_sys(clk_sys), .rst(rst), .apbReq(apbReq),
    .apbRsp(apbRsp), .pinIn(pinIn), .pinOut(pinOut), .receiveMode(receiveMode), .irq(irq));
  i2c_bus_partner bus (.pinOut(pinOut), .pinIn(pinIn));

  // ====================
  // Shared tasks
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD t=%0t %s: got %0h expected %0h", $time, what, got, exp);
    end
  endtask

  // One APB transfer; held until pready is seen high at an edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic err);
    @(posedge clk_sys);
    apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge clk_sys);
    apbReq.penable <= 1'b1;
    // No wait count assumed; only the watchdog ends a stuck access
    do
      @(posedge clk_sys);
    while (apbRsp.pready !== 1'b1);
    q = apbRsp.prdata;
    err = apbRsp.pslverr;
    apbReq <= '0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask

  // Read, mask and compare
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x,
                     input string what);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0, q, e);
    check(q & m, x, what);
  endtask

  // Poll control two until a hardware-cleared bit drops
  task automatic wait_clear(input int bitPos, output logic [31:0] q);
    logic e;
    int   n;
    n = 0;
    do
    begin
      apb(1'b0, OFF_CTRL_TWO, 32'h0, q, e);
      n++;
    end
    while (q[bitPos] !== 1'b0 && n < 25);
  endtask

  // ====================
  // Scenarios
  task automatic test_reset;
    logic [31:0] q;
    logic        e;
    rdc(OFF_CTRL_TWO, 32'hFF, {24'h0, RST_CTRL_TWO}, "ctrl2 reset");
    rdc(OFF_RELOAD, 32'hFF, {24'h0, RST_RELOAD}, "reload reset");
    rdc(OFF_CTRL_ONE, 32'h3, 32'h1, "ctrl1 reset");
    apb(1'b0, 8'h20, 32'h0, q, e);
    check(e, 1'b1, "unmapped error");
    check({pinOut.sclOut, pinOut.sdaOut}, 2'b00, "open drain data low");
    wr(OFF_BUFFER, 32'h5A);
    rdc(OFF_BUFFER, 32'hFF, 32'h5A, "buffer store");
    $display("test reset done");
  endtask

  // Software hold waits for the far side to pull SCL first
  task automatic test_hold;
    wr(OFF_CTRL_ONE, 32'h0);
    repeat (8) @(posedge clk_sys);
    check(pinOut.sclOe, 1'b0, "no hold while high");
    bus.extScl <= 1'b0;
    repeat (6) @(posedge clk_sys);
    check(pinOut.sclOe, 1'b1, "hold after low");
    bus.extScl <= 1'b1;
    repeat (6) @(posedge clk_sys);
    check(pinIn.scl, 1'b0, "still held");
    wr(OFF_CTRL_ONE, 32'h1);
    repeat (6) @(posedge clk_sys);
    check(pinIn.scl, 1'b1, "released");
    $display("test hold done");
  endtask

  // Master frame clocked by the partner; ack bit is recorded
  task automatic test_frame(input logic ack);
    wr(OFF_CTRL_ONE, 32'h3);
    bus.sendByte(8'hA4, ack);
    repeat (6) @(posedge clk_sys);
    check(pinOut.sclOe, 1'b1, "ninth edge hold");
    rdc(OFF_CTRL_TWO, 32'h40, {25'h0, ack, 6'h0}, "ack status");
    $display("test frame done");
  endtask

  // Ack sequence with a given data bit and reload count
  task automatic test_ack(input logic dt, input logic [7:0] reload);
    logic [31:0] q;
    int          n;
    wr(OFF_RELOAD, {24'h0, reload});
    wr(OFF_CTRL_TWO, {26'h0, dt, 1'b1, 4'h0});
    repeat (2) @(posedge clk_sys);
    check(pinOut.sclOe, 1'b1, "ack scl low");
    check(pinOut.sdaOe, !dt, "ack data");
    n = 0;
    while (pinOut.sclOe === 1'b1 && n < 60)
    begin
      @(posedge clk_sys);
      n++;
    end
    check(n >= reload - 1 && n <= reload + 2, 1'b1, "ack period");
    wr(OFF_BUFFER, 32'hC3);
    wait_clear(CT2_ACK_SEQ, q);
    check(q[CT2_ACK_SEQ], 1'b0, "ack enable cleared");
    check(pinOut.sclOe, 1'b1, "ack ends low");
    check(pinOut.sdaOe, 1'b0, "ack sda off");
    rdc(OFF_BUFFER, 32'hFF, 32'h5A, "buffer kept");
    rdc(OFF_INT_STAT, 32'h2, 32'h2, "collision");
    wr(OFF_INT_CLR, 32'h7);
    $display("test ack done");
  endtask

  // Stop sequence, blocked requests, interrupt mask and clear
  task automatic test_stop;
    logic [31:0] q;
    wr(OFF_INT_EN, 32'h0);
    wr(OFF_CTRL_TWO, 32'h04);
    repeat (2) @(posedge clk_sys);
    check(pinOut.sdaOe, 1'b1, "stop sda low");
    wr(OFF_BUFFER, 32'h3C);
    wr(OFF_CTRL_TWO, 32'h18);
    wait_clear(CT2_STOP, q);
    check(q[4:0], 5'h0, "stop cleared, nothing queued");
    check({pinOut.sclOe, pinOut.sdaOe}, 2'b00, "lines free");
    rdc(OFF_STATUS, 32'h1, 32'h1, "stop seen");
    rdc(OFF_INT_STAT, 32'h3, 32'h3, "flag and collision");
    rdc(OFF_BUFFER, 32'hFF, 32'h5A, "buffer kept");
    check(irq, 1'b0, "masked");
    wr(OFF_INT_EN, 32'h1);
    repeat (2) @(posedge clk_sys);
    check(irq, 1'b1, "irq raised");
    wr(OFF_INT_CLR, 32'h7);
    repeat (2) @(posedge clk_sys);
    check(irq, 1'b0, "irq cleared");
    $display("test stop done");
  endtask

  task automatic test_receive;
    wr(OFF_CTRL_TWO, 32'h08);
    repeat (2) @(posedge clk_sys);
    check(receiveMode, 1'b1, "receive mode");
    wr(OFF_CTRL_ONE, 32'h1);
    repeat (2) @(posedge clk_sys);
    check(receiveMode, 1'b0, "slave no receive");
    $display("test receive done");
  endtask

  // Slave general call with stretching on, then a frame with it off
  task automatic test_gcall;
    wr(OFF_CTRL_TWO, 32'h81);
    wr(OFF_INT_EN, 32'h4);
    bus.sendByte(GEN_CALL_ADDR, 1'b1);
    repeat (6) @(posedge clk_sys);
    check(pinOut.sclOe, 1'b1, "stretch");
    rdc(OFF_CTRL_ONE, 32'h1, 32'h0, "release cleared");
    rdc(OFF_INT_STAT, 32'h4, 32'h4, "general call");
    check(irq, 1'b1, "general call irq");
    wr(OFF_CTRL_ONE, 32'h1);
    repeat (6) @(posedge clk_sys);
    check(pinIn.scl, 1'b1, "stretch ended");
    wr(OFF_INT_CLR, 32'h7);
    wr(OFF_CTRL_TWO, 32'h0);
    bus.sendByte(8'h55, 1'b1);
    repeat (6) @(posedge clk_sys);
    check(pinOut.sclOe, 1'b0, "no stretch");
    $display("test gcall done");
  endtask

  // ====================
  // Closing report and watchdog
  task automatic end_of_test;
    $display("Compares %0d, mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Whole run needs well under a thousand cycles; a hang ends here
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fail_count++;
      end_of_test();
    end
  end

  initial
  begin
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    test_reset();
    test_hold();
    test_frame(1'b0);
    test_ack(1'b1, 8'h04);
    test_stop();
    test_frame(1'b1);
    test_ack(1'b0, 8'h08);
    test_stop();
    test_receive();
    test_gcall();
    end_of_test();
  end
endmodule
`default_nettype wire
